// >>> design/rxh_top.sv
// apb register file and host read path of the receive queue
`timescale 1ns/1ps
module rxh_top #(
  parameter int DEPTH = 16
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [rxh_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        frame_valid,
  input  wire logic [15:0]                 frame_status,
  input  wire logic [11:0]                 frame_byte_count,
  output logic                             frame_ready,
  output logic      [rxh_pkg::PTR_W-1:0]   qmem_addr,
  input  wire logic [15:0]                 qmem_rdata,
  output logic                             frame_release,
  output logic                             irq
);
  localparam int CW = $clog2(DEPTH + 1);

  logic [31:0]                prdata_reg;
  logic                       pready_reg;
  logic                       pslverr_reg;
  logic [15:0]                qctrl_reg;
  logic                       autoinc_reg;
  logic [rxh_pkg::PTR_W-1:0]  ptr_reg;
  logic [15:0]                irq_en_reg;
  logic [15:0]                irq_st_reg;
  logic [1:0]                 cfg_reg;
  logic [rxh_pkg::TALLY_W-1:0] tally_reg;
  logic [15:0]                hdr_st_reg;
  logic [15:0]                hdr_bc_reg;
  logic                       st_seen_reg;
  logic                       bc_seen_reg;
  logic                       adv_reg;
  logic                       release_reg;
  logic                       irq_reg;
  logic                       frame_ready_reg;
  rxh_pkg::rxh_dma_e          dma_reg;
  rxh_pkg::rxh_dma_e          dma_next;

  logic                       fifo_full;
  logic                       head_valid;
  logic [27:0]                head_data;
  logic [CW-1:0]              fifo_count;

  function automatic logic hit(input logic [rxh_pkg::ADDR_W-1:0] a, input logic [9:0] idx);
    hit = (a[rxh_pkg::ADDR_W-1:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  // bus phases: no wait state, effects at the completing edge
  wire setup   = psel & ~penable & ~pready_reg;
  wire access  = psel & penable & pready_reg;
  wire wr_acc  = access & pwrite;
  wire rd_acc  = access & ~pwrite;

  wire d_hs    = hit(paddr, rxh_pkg::IDX_HDR_STATUS);
  wire d_hbc   = hit(paddr, rxh_pkg::IDX_HDR_BC);
  wire d_qctl  = hit(paddr, rxh_pkg::IDX_QCTRL);
  wire d_data  = hit(paddr, rxh_pkg::IDX_DATA);
  wire d_fdp   = hit(paddr, rxh_pkg::IDX_FDP);
  wire d_ien   = hit(paddr, rxh_pkg::IDX_IRQ_EN);
  wire d_ist   = hit(paddr, rxh_pkg::IDX_IRQ_STATUS);
  wire d_iclr  = hit(paddr, rxh_pkg::IDX_IRQ_CLEAR);
  wire d_cfg   = hit(paddr, rxh_pkg::IDX_CFG);
  wire d_tally = hit(paddr, rxh_pkg::IDX_TALLY);
  wire mapped  = d_hs | d_hbc | d_qctl | d_data | d_fdp | d_ien | d_ist | d_iclr | d_cfg | d_tally;

  wire bus8    = cfg_reg[rxh_pkg::CFG_BUS8_BIT];
  wire bigend  = cfg_reg[rxh_pkg::CFG_BIGEND_BIT];
  wire dma_on  = qctrl_reg[rxh_pkg::QCTRL_DMA_BIT];
  wire autodeq = qctrl_reg[rxh_pkg::QCTRL_AUTODEQ_BIT];

  wire [15:0] bc_view   = bigend ? {hdr_bc_reg[7:0], hdr_bc_reg[15:8]} : hdr_bc_reg;
  wire [15:0] data_word = bus8 ? {8'h00, (ptr_reg[0] ? qmem_rdata[15:8] : qmem_rdata[7:0])} : qmem_rdata;
  wire [15:0] data_view = (dma_reg == rxh_pkg::RXH_DMA_DATA) ? data_word : 16'h0000;
  wire [15:0] fdp_view  = {1'b0, autoinc_reg, 3'h0, ptr_reg};
  wire [15:0] tally_view = {tally_reg, 8'h00};
  wire [15:0] rdata =
    d_hs    ? hdr_st_reg :
    d_hbc   ? bc_view    :
    d_qctl  ? qctrl_reg  :
    d_data  ? data_view  :
    d_fdp   ? fdp_view   :
    d_ien   ? irq_en_reg :
    d_ist   ? irq_st_reg :
    d_cfg   ? {14'h0000, cfg_reg} :
    d_tally ? tally_view : 16'h0000;

  // data register access and pointer stepping
  wire data_rd   = rd_acc & d_data;
  wire data_take = data_rd & (dma_reg == rxh_pkg::RXH_DMA_DATA);
  wire [rxh_pkg::PTR_W-1:0] step     = bus8 ? 11'h001 : 11'h002;
  wire [rxh_pkg::PTR_W-1:0] ptr_step = ptr_reg + step;
  // aligned frame length: byte count rounded up to a double word
  wire [12:0] aligned_len = (13'(hdr_bc_reg[11:0]) + 13'h0003) & 13'h1ffc;
  wire rel_hit = data_take & autodeq & (13'(ptr_step) >= aligned_len);

  // interrupt status: set wins over clear
  wire [15:0] irq_set = {2'b00, (frame_valid & ~fifo_full), 12'h000, (frame_valid & fifo_full)};
  wire [15:0] irq_clr = (wr_acc & d_iclr) ? pwdata[15:0] : 16'h0000;
  wire [15:0] irq_st_next = (irq_st_reg & ~irq_clr) | irq_set;

  // header registers
  wire tally_rd  = rd_acc & d_tally;
  wire st_seen_n = st_seen_reg | (rd_acc & d_hs);
  wire bc_seen_n = bc_seen_reg | (rd_acc & d_hbc);
  wire both_seen = ~tally_rd & st_seen_n & bc_seen_n;
  wire [27:0] head_view = head_valid ? head_data : 28'h0000000;

  always_comb begin
    dma_next = dma_reg;
    unique case (dma_reg)
      rxh_pkg::RXH_DMA_IDLE:  if (dma_on) dma_next = rxh_pkg::RXH_DMA_DUMMY;
      rxh_pkg::RXH_DMA_DUMMY: if (!dma_on) dma_next = rxh_pkg::RXH_DMA_IDLE;
                              else if (data_rd) dma_next = rxh_pkg::RXH_DMA_DATA;
      rxh_pkg::RXH_DMA_DATA:  if (!dma_on) dma_next = rxh_pkg::RXH_DMA_IDLE;
      default:                dma_next = rxh_pkg::RXH_DMA_IDLE;
    endcase
  end

  rxh_desc_fifo #(
    .W     (28),
    .DEPTH (DEPTH),
    .CW    (CW)
  ) u_desc (
    .pclk       (pclk),
    .presetn    (presetn),
    .push       (frame_valid),
    .push_data  ({frame_byte_count, frame_status}),
    .pop        (both_seen),
    .full       (fifo_full),
    .head_valid (head_valid),
    .head_data  (head_data),
    .count      (fifo_count)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h00000000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup & ~mapped;
      if (setup) prdata_reg <= (pwrite ? 32'h00000000 : {16'h0000, rdata});
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qctrl_reg  <= rxh_pkg::QCTRL_RST;
      irq_en_reg <= rxh_pkg::IRQ_EN_RST;
      cfg_reg    <= rxh_pkg::CFG_RST;
      irq_st_reg <= 16'h0000;
      irq_reg    <= 1'b0;
      dma_reg    <= rxh_pkg::RXH_DMA_IDLE;
      frame_ready_reg <= 1'b1;
    end else begin
      if (wr_acc & d_qctl) qctrl_reg <= pwdata[15:0];
      if (wr_acc & d_ien) irq_en_reg <= pwdata[15:0];
      if (wr_acc & d_cfg) cfg_reg <= pwdata[1:0];
      irq_st_reg <= irq_st_next;
      irq_reg    <= |(irq_st_next & irq_en_reg);
      dma_reg    <= dma_next;
      frame_ready_reg <= ~fifo_full;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_reg     <= '0;
      autoinc_reg <= 1'b0;
      release_reg <= 1'b0;
    end else begin
      release_reg <= rel_hit;
      if (wr_acc & d_fdp) begin
        ptr_reg     <= pwdata[rxh_pkg::PTR_W-1:0];
        autoinc_reg <= pwdata[rxh_pkg::FDP_AUTOINC_BIT];
      end else if (rel_hit) begin
        ptr_reg <= '0;
      end else if (data_take & autoinc_reg) begin
        ptr_reg <= ptr_step;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tally_reg   <= '0;
      hdr_st_reg  <= 16'h0000;
      hdr_bc_reg  <= 16'h0000;
      st_seen_reg <= 1'b0;
      bc_seen_reg <= 1'b0;
      adv_reg     <= 1'b0;
    end else begin
      if (irq_clr[rxh_pkg::IRQ_RX_BIT]) tally_reg <= rxh_pkg::TALLY_W'(fifo_count);
      adv_reg <= both_seen;
      if (tally_rd | adv_reg) begin
        hdr_st_reg <= head_view[15:0];
        hdr_bc_reg <= {4'h0, head_view[27:16]};
      end
      st_seen_reg <= ~tally_rd & ~both_seen & st_seen_n;
      bc_seen_reg <= ~tally_rd & ~both_seen & bc_seen_n;
    end
  end

  assign prdata        = prdata_reg;
  assign pready        = pready_reg;
  assign pslverr       = pslverr_reg;
  assign frame_ready   = frame_ready_reg;
  assign qmem_addr     = ptr_reg;
  assign frame_release = release_reg;
  assign irq           = irq_reg;

  sequence s_both_read;
    both_seen ##1 adv_reg;
  endsequence

  a_dummy_first: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && d_data && dma_reg == rxh_pkg::RXH_DMA_DUMMY) |=> (prdata_reg == 32'h0))
    else $error("dummy read not zero");
  a_dma_start: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && d_qctl && pwdata[3] && dma_reg == rxh_pkg::RXH_DMA_IDLE) |=> ##1 (dma_reg == rxh_pkg::RXH_DMA_DUMMY))
    else $error("dma did not start");
  a_tally_load: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && d_iclr && pwdata[13]) |=> (tally_reg == rxh_pkg::TALLY_W'($past(fifo_count))))
    else $error("tally not loaded");
  a_hdr_load: assert property (@(posedge pclk) disable iff (!presetn)
    tally_rd |=> (hdr_st_reg == $past(head_view[15:0])))
    else $error("header not loaded");
  a_hdr_adv: assert property (@(posedge pclk) disable iff (!presetn)
    s_both_read |=> (hdr_bc_reg[11:0] == $past(head_view[27:16])))
    else $error("header not advanced");
  a_auto_inc: assert property (@(posedge pclk) disable iff (!presetn)
    (data_take && autoinc_reg && !rel_hit && !(wr_acc && d_fdp)) |=> (ptr_reg == $past(ptr_step)))
    else $error("pointer not stepped");
  a_bc_swap: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && d_hbc && bigend) |=> (prdata_reg[15:0] == {$past(hdr_bc_reg[7:0]), $past(hdr_bc_reg[15:8])}))
    else $error("byte count not swapped");
  a_clear_all: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && d_iclr && pwdata[15:0] == rxh_pkg::CLEAR_ALL && !frame_valid) |=> (irq_st_reg == 16'h0 && !irq_reg))
    else $error("status not cleared");
  a_release: assert property (@(posedge pclk) disable iff (!presetn)
    rel_hit |=> (frame_release && ptr_reg == '0))
    else $error("frame not released");
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready_reg |=> !pready_reg)
    else $error("pready held");
endmodule

// >>> design/rxh_pkg.sv
// constants, register map and types for the receive queue host read path
// What this block does
// - every dma read burst gives one leading dummy byte or word first, which the host throws away.
// - writing one to the receive interrupt clear bit loads the frame tally with the frames pending.
// - reading the frame tally loads header status and header byte count with the first pending frame.
// - once both header registers have been read they advance to the next pending frame.
// - setting bit 3 of the queue control register starts a host dma access to queue data.
// - with bit 14 of the frame data pointer set, each data register read after the dma dummy read steps the queue address, or clears it on a frame release.
// - in big-endian mode the header byte count is shown with its two bytes swapped.
// - writing all ones to the interrupt clear register clears every status bit not set again by a frame in the same cycle.
package rxh_pkg;
  localparam int          ADDR_W            = 12;
  localparam int          IDX_W             = 10;
  localparam int          PTR_W             = 11;
  localparam int          TALLY_W           = 8;
  // register indices; byte address is four times the index
  localparam logic [9:0]  IDX_HDR_STATUS    = 10'h17c;
  localparam logic [9:0]  IDX_HDR_BC        = 10'h17e;
  localparam logic [9:0]  IDX_QCTRL         = 10'h182;
  localparam logic [9:0]  IDX_DATA          = 10'h184;
  localparam logic [9:0]  IDX_FDP           = 10'h186;
  localparam logic [9:0]  IDX_IRQ_EN        = 10'h190;
  localparam logic [9:0]  IDX_IRQ_STATUS    = 10'h192;
  localparam logic [9:0]  IDX_IRQ_CLEAR     = 10'h194;
  localparam logic [9:0]  IDX_CFG           = 10'h196;
  localparam logic [9:0]  IDX_TALLY         = 10'h1b8;
  // field positions
  localparam int          QCTRL_DMA_BIT     = 3;
  localparam int          QCTRL_AUTODEQ_BIT = 4;
  localparam int          FDP_AUTOINC_BIT   = 14;
  localparam int          IRQ_RX_BIT        = 13;
  localparam int          IRQ_OVF_BIT       = 0;
  localparam int          CFG_BUS8_BIT      = 0;
  localparam int          CFG_BIGEND_BIT    = 1;
  localparam int          TALLY_LSB         = 8;
  localparam logic [15:0] CLEAR_ALL         = 16'hffff;
  // reset values and descriptor queue depth
  localparam logic [15:0] QCTRL_RST         = 16'h0000;
  localparam logic [15:0] IRQ_EN_RST        = 16'h0000;
  localparam logic [1:0]  CFG_RST           = 2'h0;
  localparam logic [15:0] DESC_DEPTH        = 16'h0010;

  typedef enum logic [1:0] {
    RXH_DMA_IDLE  = 2'b00,
    RXH_DMA_DUMMY = 2'b01,
    RXH_DMA_DATA  = 2'b11
  } rxh_dma_e;
endpackage

// >>> design/rxh_desc_fifo.sv
// descriptor queue of received frames awaiting the host
`timescale 1ns/1ps
module rxh_desc_fifo #(
  parameter int W     = 28,
  parameter int DEPTH = 16,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          push,
  input  wire logic [W-1:0]  push_data,
  input  wire logic          pop,
  output logic               full,
  output logic               head_valid,
  output logic [W-1:0]       head_data,
  output logic [CW-1:0]      count
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic          full_reg;
  wire           do_push = push & ~full_reg;
  wire           do_pop  = pop & (count_reg != '0);

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign count_next = count_reg + CW'(do_push) - CW'(do_pop);
  assign full       = full_reg;
  assign count      = count_reg;
  assign head_valid = (count_reg != '0);
  assign head_data  = mem[rd_ptr_reg];

  always_ff @(posedge pclk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= push_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      full_reg   <= 1'b0;
    end else begin
      if (do_push) wr_ptr_reg <= wrap_inc(wr_ptr_reg);
      if (do_pop) rd_ptr_reg <= wrap_inc(rd_ptr_reg);
      count_reg <= count_next;
      full_reg  <= (count_next == CW'(DEPTH));
    end
  end
endmodule

// >>> verif/rxh_switch_model.sv
// switch-side model: frame source and receive queue memory
`timescale 1ns/1ps
module rxh_switch_model (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      send,
  input  wire logic [15:0]               send_status,
  input  wire logic [11:0]               send_bc,
  input  wire logic                      frame_ready,
  output logic                           frame_valid,
  output logic      [15:0]               frame_status,
  output logic      [11:0]               frame_byte_count,
  input  wire logic [rxh_pkg::PTR_W-1:0] qmem_addr,
  output logic      [15:0]               qmem_rdata,
  input  wire logic                      frame_release,
  output int                             releases
);
  // frame_ready is not honoured: the bench commands overflow on purpose
  function automatic logic [7:0] pat(input logic [rxh_pkg::PTR_W-1:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction
  // low byte at the even address, pair aligned
  wire [rxh_pkg::PTR_W-1:0] pair_base = {qmem_addr[rxh_pkg::PTR_W-1:1], 1'b0};
  assign qmem_rdata = {pat(pair_base + 11'h001), pat(pair_base)};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_valid      <= 1'b0;
      frame_status     <= 16'h0000;
      frame_byte_count <= 12'h000;
      releases         <= 0;
    end else begin
      frame_valid      <= send;
      // stale qualifiers toggle so nothing leans on them outside a frame
      frame_status     <= send ? send_status : ~frame_status;
      frame_byte_count <= send ? send_bc : ~frame_byte_count;
      if (frame_release) releases <= releases + 1;
    end
  end
endmodule

// >>> verif/tb_top.sv
// self-checking bench for the receive queue host read path
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pslverr, pready, irq, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        frame_valid, frame_ready, frame_release, send;
  logic [15:0] frame_status, qmem_rdata, send_status;
  logic [11:0] frame_byte_count, send_bc;
  logic [10:0] qmem_addr;
  int          n_errors, num_checks, rel, i;

  rxh_top #(.DEPTH(2)) u_rxh_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_valid(frame_valid), .frame_status(frame_status), .frame_byte_count(frame_byte_count),
    .frame_ready(frame_ready), .qmem_addr(qmem_addr), .qmem_rdata(qmem_rdata),
    .frame_release(frame_release), .irq(irq));
  rxh_switch_model u_rxh_switch_model (.pclk(pclk), .presetn(presetn), .send(send),
    .send_status(send_status), .send_bc(send_bc), .frame_ready(frame_ready), .frame_valid(frame_valid),
    .frame_status(frame_status), .frame_byte_count(frame_byte_count), .qmem_addr(qmem_addr),
    .qmem_rdata(qmem_rdata), .frame_release(frame_release), .releases(rel));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic results();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [9:0] x, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {x, 2'b00};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      results();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [9:0] x, input logic [15:0] e);
    apb(1'b0, x, 32'h0);
    `CHK(rd, {16'h0000, e})
  endtask

  task automatic frame(input logic [15:0] s, input logic [11:0] b);
    @(posedge pclk);
    send        <= 1'b1;
    send_status <= s;
    send_bc     <= b;
    @(posedge pclk);
    send <= 1'b0;
  endtask

  function automatic logic [7:0] p(input int x);
    return 8'(x) ^ 8'h5a;
  endfunction

  initial begin
    {psel, penable, pwrite, paddr, pwdata, send, send_status, send_bc, presetn} = '0;
    n_errors   = 0;
    num_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rchk(rxh_pkg::IDX_IRQ_STATUS, 16'h0000);
    rchk(rxh_pkg::IDX_QCTRL, rxh_pkg::QCTRL_RST);
    rchk(rxh_pkg::IDX_IRQ_EN, rxh_pkg::IRQ_EN_RST);
    rchk(rxh_pkg::IDX_CFG, 16'h0000);
    apb(1'b0, 10'h3ff, 32'h0);
    `CHK(er, 1'b1)
    apb(1'b1, rxh_pkg::IDX_IRQ_EN, 32'h2001);
    frame(16'h8001, 12'd65);
    frame(16'h8002, 12'd4);
    frame(16'h8003, 12'd8);
    repeat (3) @(negedge pclk);
    `CHK(frame_ready, 1'b0)
    `CHK(irq, 1'b1)
    apb(1'b1, rxh_pkg::IDX_IRQ_STATUS, 32'h0);
    rchk(rxh_pkg::IDX_IRQ_STATUS, 16'h2001);
    apb(1'b1, rxh_pkg::IDX_IRQ_EN, 32'h0);
    repeat (2) @(negedge pclk);
    `CHK(irq, 1'b0)
    apb(1'b1, rxh_pkg::IDX_IRQ_EN, 32'h2001);
    apb(1'b1, rxh_pkg::IDX_IRQ_CLEAR, 32'h2000);
    rchk(rxh_pkg::IDX_TALLY, 16'h0200);
    rchk(rxh_pkg::IDX_IRQ_STATUS, 16'h0001);
    apb(1'b1, rxh_pkg::IDX_IRQ_CLEAR, {16'h0, rxh_pkg::CLEAR_ALL});
    rchk(rxh_pkg::IDX_IRQ_STATUS, 16'h0000);
    `CHK(irq, 1'b0)
    rchk(rxh_pkg::IDX_HDR_STATUS, 16'h8001);
    apb(1'b1, rxh_pkg::IDX_FDP, 32'h4000);
    apb(1'b1, rxh_pkg::IDX_QCTRL, 32'h0018);
    repeat (2) @(posedge pclk);
    rchk(rxh_pkg::IDX_DATA, 16'h0000);
    // 65 bytes read on to 68
    for (i = 0; i < 34; i++) begin
      `CHK(rel, 0)
      rchk(rxh_pkg::IDX_DATA, {p(2 * i + 1), p(2 * i)});
    end
    repeat (3) @(negedge pclk);
    `CHK(rel, 1)
    rchk(rxh_pkg::IDX_FDP, 16'h4000);
    apb(1'b1, rxh_pkg::IDX_CFG, 32'h2);
    rchk(rxh_pkg::IDX_HDR_BC, 16'h4100);
    apb(1'b1, rxh_pkg::IDX_CFG, 32'h0);
    repeat (2) @(posedge pclk);
    rchk(rxh_pkg::IDX_HDR_STATUS, 16'h8002);
    rchk(rxh_pkg::IDX_HDR_BC, 16'h0004);
    apb(1'b1, rxh_pkg::IDX_QCTRL, 32'h0);
    apb(1'b1, rxh_pkg::IDX_CFG, 32'h1);
    apb(1'b1, rxh_pkg::IDX_QCTRL, 32'h0008);
    repeat (2) @(posedge pclk);
    rchk(rxh_pkg::IDX_DATA, 16'h0000);
    for (i = 0; i < 3; i++) rchk(rxh_pkg::IDX_DATA, {8'h00, p(i)});
    results();
  end
endmodule
